// >>> rtl/panel_pkg.sv
// panel_pkg: constants shared by the front panel control block
// assumes a 100 MHz system clock and a 32-bit classic wishbone register bus
package panel_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  // switch contacts must be stable this long before a level is accepted
  localparam int DEBOUNCE_US = 5000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  // lamp stretch, long enough that rapid alternation lights both lamps
  localparam int LAMP_HOLD_US = 10;
  localparam int LAMP_HOLD_CYC = LAMP_HOLD_US * CLK_MHZ;
  // width of the system reset pulse
  localparam int RESET_HOLD_NS = 200;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * CLK_MHZ) / 1000;

  // ---------------------------------------------------------------
  // panel layout
  // ---------------------------------------------------------------
  localparam int NUM_LEVELS = 8;
  localparam int NUM_SW = 10;        // eight requests, reset, boot
  localparam int SW_RESET = 8;
  localparam int SW_BOOT = 9;
  localparam int EVT_W = 9;          // eight presses plus reset event
  localparam int EVT_RESET = 8;
  localparam logic [15:0] SHADOW_TOP = 16'h00ff;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_SOFT_REQ = 8'h08;
  localparam logic [7:0] REG_PANEL = 8'h0c;
  localparam logic [EVT_W-1:0] MASK_RESET = 9'h000;
  localparam int PANEL_BOOT_BIT = 8;
  localparam int PANEL_HALT_BIT = 9;
  localparam int PANEL_RUN_BIT = 10;

  // reset pulse sequencer
  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_PULSE = 3'b010,
    RS_WAIT_UP = 3'b100
  } rst_state_e;

endpackage

// >>> rtl/panel_ctrl.sv
// panel_ctrl: front panel control - request switches, lamps, boot, reset
// assumes switch inputs are asynchronous, processor supplies state and
// per-level service strobes, and a classic wishbone master drives the bus
//
// Functional notes
// RQ1: eight switches raise same-numbered bus requests
// RQ2: level lamp lit while request pending
// RQ3: halt and run lamps follow processor
// RQ4: both dark waits, both lit alternates
// RQ5: reset zeroes counter, clears pending, initialises
// RQ6: reset never writes or clears RAM
// RQ7: boot selector holds bootstrap mode
// RQ8: bootstrap reads low page from shadow
// RQ9: processor prioritises and masks levels
// RQ10: switches synchronised, debounced, one request each
`timescale 1ns/1ps
module panel_ctrl
  import panel_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_IRQ,
  input wire logic [7:0] I_REQ_SW,
  input wire logic I_RESET_SW,
  input wire logic I_BOOT_SW,
  input wire logic [7:0] I_SERVICED,
  input wire logic I_CPU_HALTED,
  input wire logic I_CPU_RUNNING,
  input wire logic [15:0] I_MEM_ADDR,
  input wire logic I_MEM_RD,
  input wire logic I_MEM_WR,
  output logic [7:0] O_INT_REQ,
  output logic [7:0] O_LAMP_INT,
  output logic O_LAMP_HALT,
  output logic O_LAMP_RUN,
  output logic O_SYS_RESET,
  output logic O_BOOT_MODE,
  output logic O_SHADOW_RD,
  output logic O_RAM_RD,
  output logic O_RAM_WR
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // low page decode, shared by the memory steering and its check
  function automatic logic in_shadow(input logic [15:0] addr);
    in_shadow = (addr <= SHADOW_TOP);
  endfunction

  // ---------------------------------------------------------------
  // switch conditioning
  // ---------------------------------------------------------------
  logic [NUM_SW-1:0] sw_raw;
  logic [NUM_SW-1:0] sync1_r;
  logic [NUM_SW-1:0] sync2_r;
  logic [NUM_SW-1:0] deb_r;
  logic [NUM_SW-1:0] deb_d_r;
  logic [NUM_SW-1:0] sw_rise;

  assign sw_raw = {I_BOOT_SW, I_RESET_SW, I_REQ_SW};
  assign sw_rise = deb_r & ~deb_d_r;

  // two-stage synchroniser; stage one feeds only stage two
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      sync1_r <= '0;
      sync2_r <= '0;
      deb_d_r <= '0;
    end else begin
      sync1_r <= sw_raw;
      sync2_r <= sync1_r;
      deb_d_r <= deb_r;
    end
  end

  // RQ10: per-switch stability filter
  genvar g;
  generate
    for (g = 0; g < NUM_SW; g++) begin : g_deb
      logic [19:0] cnt_r;
      logic stable;
      assign stable = (cnt_r == 20'(DEBOUNCE_CYCLES - 1));
      // a contact must hold its new level for the full window;
      // any bounce restarts the count, so one press makes one edge
      always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
          cnt_r <= '0;
          deb_r[g] <= 1'b0;
        end else if (sync2_r[g] == deb_r[g]) begin
          cnt_r <= '0;
        end else if (stable) begin
          cnt_r <= '0;
          deb_r[g] <= sync2_r[g];
        end else begin
          cnt_r <= cnt_r + 20'h00001;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // reset switch sequencer
  // ---------------------------------------------------------------
  rst_state_e rs_r;
  rst_state_e rs_nxt;
  logic [7:0] rs_cnt_r;
  logic rs_done;
  logic sys_rst_nxt;

  assign rs_done = (rs_cnt_r == 8'(RESET_HOLD_CYC - 1));

  // one fixed-width pulse per press; held switch does not retrigger
  always_comb begin
    rs_nxt = rs_r;
    case (rs_r)
      RS_IDLE: if (sw_rise[SW_RESET]) rs_nxt = RS_PULSE;
      RS_PULSE: if (rs_done) rs_nxt = RS_WAIT_UP;
      RS_WAIT_UP: if (!deb_r[SW_RESET]) rs_nxt = RS_IDLE;
      default: rs_nxt = RS_IDLE;
    endcase
  end
  assign sys_rst_nxt = (rs_nxt == RS_PULSE);

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      rs_r <= RS_IDLE;
      rs_cnt_r <= '0;
    end else begin
      rs_r <= rs_nxt;
      rs_cnt_r <= (rs_r == RS_PULSE) ? rs_cnt_r + 8'h01 : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  logic [EVT_W-1:0] status_r;
  logic [EVT_W-1:0] mask_r;
  logic [7:0] pend_r;
  logic halt_lamp_r;
  logic run_lamp_r;
  logic wb_req;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] rdata;
  logic [7:0] soft_req;

  // ack one cycle after the strobe; write and read-clear land on the
  // edge at which the master samples ack, keeping both atomic
  assign wb_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  assign wr_fire = I_WB_CYC & I_WB_STB & I_WB_WE & O_WB_ACK;
  assign rd_fire = I_WB_CYC & I_WB_STB & ~I_WB_WE & O_WB_ACK &
                   (I_WB_ADR == REG_STATUS);
  assign soft_req = (wr_fire && I_WB_ADR == REG_SOFT_REQ && I_WB_SEL[0]) ?
                    I_WB_DAT[7:0] : 8'h00;

  // unmapped offsets read as zero and are still acknowledged
  always_comb begin
    rdata = 32'h00000000;
    case (I_WB_ADR)
      REG_STATUS: rdata[EVT_W-1:0] = status_r;
      REG_MASK: rdata[EVT_W-1:0] = mask_r;
      REG_PANEL: begin
        rdata[7:0] = pend_r;
        rdata[PANEL_BOOT_BIT] = O_BOOT_MODE;
        rdata[PANEL_HALT_BIT] = halt_lamp_r;
        rdata[PANEL_RUN_BIT] = run_lamp_r;
      end
      default: rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h00000000;
    end else begin
      O_WB_ACK <= wb_req;
      if (wb_req && !I_WB_WE) O_WB_DAT <= rdata;
    end
  end

  // mask register, byte lanes honoured
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      mask_r <= MASK_RESET;
    end else if (wr_fire && I_WB_ADR == REG_MASK) begin
      if (I_WB_SEL[0]) mask_r[7:0] <= I_WB_DAT[7:0];
      if (I_WB_SEL[1]) mask_r[8] <= I_WB_DAT[8];
    end
  end

  // ---------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------
  logic [EVT_W-1:0] events;
  logic [EVT_W-1:0] rd_clear;
  logic [EVT_W-1:0] status_nxt;

  assign events = {sw_rise[SW_RESET], sw_rise[7:0]};
  // only bits the read returned are cleared; new events win
  assign rd_clear = rd_fire ? O_WB_DAT[EVT_W-1:0] : '0;
  assign status_nxt = (status_r & ~rd_clear) | events;

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      status_r <= '0;
      O_IRQ <= 1'b0;
    end else begin
      status_r <= status_nxt;
      O_IRQ <= |(status_nxt & mask_r);
    end
  end

  // ---------------------------------------------------------------
  // pending requests and lamps
  // ---------------------------------------------------------------
  logic [7:0] pend_nxt;

  // RQ1: press or software sets the level
  // RQ2: service clears, set wins over clear
  // RQ5: reset pulse clears every level
  // RQ9: levels are driven raw; priority and masking live in the cpu
  assign pend_nxt = sys_rst_nxt ? 8'h00 :
                    (pend_r & ~I_SERVICED) | sw_rise[7:0] | soft_req;

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      pend_r <= '0;
      O_INT_REQ <= '0;
      O_LAMP_INT <= '0;
      O_SYS_RESET <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      O_INT_REQ <= pend_nxt;
      O_LAMP_INT <= pend_nxt;
      O_SYS_RESET <= sys_rst_nxt;
    end
  end

  // RQ3: stretched processor state lamps
  // RQ4: stretch makes alternation light both, wait lights neither
  logic [9:0] halt_cnt_r;
  logic [9:0] run_cnt_r;
  logic halt_nxt;
  logic run_nxt;

  assign halt_nxt = I_CPU_HALTED | (halt_cnt_r != 10'h000);
  assign run_nxt = I_CPU_RUNNING | (run_cnt_r != 10'h000);

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      halt_cnt_r <= '0;
      run_cnt_r <= '0;
      halt_lamp_r <= 1'b0;
      run_lamp_r <= 1'b0;
      O_LAMP_HALT <= 1'b0;
      O_LAMP_RUN <= 1'b0;
    end else begin
      halt_cnt_r <= I_CPU_HALTED ? 10'(LAMP_HOLD_CYC - 1) :
                    (halt_cnt_r != 10'h000) ? halt_cnt_r - 10'h001 : 10'h000;
      run_cnt_r <= I_CPU_RUNNING ? 10'(LAMP_HOLD_CYC - 1) :
                   (run_cnt_r != 10'h000) ? run_cnt_r - 10'h001 : 10'h000;
      halt_lamp_r <= halt_nxt;
      run_lamp_r <= run_nxt;
      O_LAMP_HALT <= halt_nxt;
      O_LAMP_RUN <= run_nxt;
    end
  end

  // ---------------------------------------------------------------
  // boot mode and memory steering
  // ---------------------------------------------------------------
  logic low_page;
  assign low_page = in_shadow(I_MEM_ADDR);

  // RQ7: boot mode tracks the debounced selector level
  // RQ8: shadow takes low-page reads only
  // RQ6: writes always pass to ram, reset issues none
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      O_BOOT_MODE <= 1'b0;
      O_SHADOW_RD <= 1'b0;
      O_RAM_RD <= 1'b0;
      O_RAM_WR <= 1'b0;
    end else begin
      O_BOOT_MODE <= deb_r[SW_BOOT];
      O_SHADOW_RD <= I_MEM_RD & low_page & deb_r[SW_BOOT];
      O_RAM_RD <= I_MEM_RD & ~(low_page & deb_r[SW_BOOT]);
      O_RAM_WR <= I_MEM_WR;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);

  property p_req_press;
    (sw_rise[0] && !sys_rst_nxt) |=> O_INT_REQ[0] && O_LAMP_INT[0];
  endproperty
  a_req_press: assert property (p_req_press) else $error("press lost"); // RQ1

  property p_lamp_serviced;
    (O_LAMP_INT[3] && I_SERVICED[3] && !sw_rise[3] && !soft_req[3])
      |=> !O_LAMP_INT[3];
  endproperty
  a_lamp_serviced: assert property (p_lamp_serviced) else $error("lamp stuck"); // RQ2

  property p_lamp_equals_req;
    O_LAMP_INT == O_INT_REQ;
  endproperty
  a_lamp_equals_req: assert property (p_lamp_equals_req) else $error("lamp mismatch"); // RQ2

  property p_halt_lamp;
    I_CPU_HALTED |=> O_LAMP_HALT [*8];
  endproperty
  a_halt_lamp: assert property (p_halt_lamp) else $error("halt lamp dark"); // RQ3

  // helper: run of consecutive wait cycles, saturating well past the stretch
  logic [10:0] wait_cnt_r;
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      wait_cnt_r <= '0;
    end else if (I_CPU_HALTED || I_CPU_RUNNING) begin
      wait_cnt_r <= '0;
    end else if (wait_cnt_r != 11'h7ff) begin
      wait_cnt_r <= wait_cnt_r + 11'h001;
    end
  end

  property p_wait_dark;
    (wait_cnt_r >= 11'(LAMP_HOLD_CYC + 2)) |-> !O_LAMP_HALT && !O_LAMP_RUN;
  endproperty
  a_wait_dark: assert property (p_wait_dark) else $error("wait not dark"); // RQ4

  property p_reset_clears;
    O_SYS_RESET |-> O_INT_REQ == 8'h00;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset kept req"); // RQ5

  property p_reset_width;
    $rose(O_SYS_RESET) |-> O_SYS_RESET [*8] ##[0:20] !O_SYS_RESET;
  endproperty
  a_reset_width: assert property (p_reset_width) else $error("reset width"); // RQ5

  property p_no_ram_write;
    !I_MEM_WR |=> !O_RAM_WR;
  endproperty
  a_no_ram_write: assert property (p_no_ram_write) else $error("stray ram write"); // RQ6

  property p_boot_hold;
    deb_r[SW_BOOT] |=> O_BOOT_MODE;
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("boot lost"); // RQ7

  property p_shadow_read;
    (I_MEM_RD && in_shadow(I_MEM_ADDR) && deb_r[SW_BOOT])
      |=> O_SHADOW_RD && !O_RAM_RD;
  endproperty
  a_shadow_read: assert property (p_shadow_read) else $error("shadow miss"); // RQ8

  property p_one_edge;
    sw_rise[1] |=> !sw_rise[1] [*2];
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("double edge"); // RQ10

  c_press: cover property (sw_rise[0] ##[1:50] I_SERVICED[0]);
  c_alternate: cover property (O_LAMP_HALT && O_LAMP_RUN);
  c_reset: cover property ($rose(O_SYS_RESET));
  c_shadow: cover property (O_SHADOW_RD);

endmodule

// >>> tb/cpu_model.sv
// cpu_model: processor-side partner of the front panel block
// assumes one clock shared with the panel and an active-high async reset
`timescale 1ns/1ps
module cpu_model (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_int_req,
  input wire logic [7:0] i_mask,
  input wire logic i_serve_en,
  input wire logic [1:0] i_state,
  output logic [7:0] o_serviced,
  output logic o_halted,
  output logic o_running
);
  // ---------------------------------------------------------------
  // priority service
  // ---------------------------------------------------------------
  logic [7:0] open_w;
  logic [7:0] pick_w;
  logic flip_r;
  // lowest-numbered open level wins; two's complement isolates it
  // encoder and mask
  assign open_w = i_int_req & ~i_mask;
  assign pick_w = open_w & (~open_w + 8'h01);
  // no back-to-back strobe, so the panel has a cycle to drop the level
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_serviced <= 8'h00;
    end else begin
      o_serviced <= (i_serve_en && o_serviced == 8'h00) ? pick_w : 8'h00;
    end
  end
  // ---------------------------------------------------------------
  // run state: 00 wait, 01 run, 10 halt, 11 alternate each cycle
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      flip_r <= 1'b0;
    end else begin
      flip_r <= ~flip_r;
    end
  end
  assign o_halted = (i_state == 2'b10) || (i_state == 2'b11 && flip_r);
  assign o_running = (i_state == 2'b01) || (i_state == 2'b11 && !flip_r);
endmodule

// >>> tb/test_front_panel_control.sv
// test_front_panel_control: directed bench for the panel control block
// assumes the short debounce parameter and the processor partner model
`timescale 1ns/1ps
module test_front_panel_control
  import panel_pkg::*;
;
  logic clk, rst, cyc, stb, wb_we, rst_sw, boot_sw, mem_rd, mem_wr, serve;
  logic [7:0] wb_adr, req_sw, cpu_mask, serviced;
  logic [31:0] wb_wd, O_WB_DAT, rd;
  logic [15:0] mem_adr;
  logic [1:0] cpu_state;
  logic O_WB_ACK, O_IRQ, halted, running, O_LAMP_HALT, O_LAMP_RUN;
  logic O_SYS_RESET, O_BOOT_MODE, O_SHADOW_RD, O_RAM_RD, O_RAM_WR, wr_seen;
  logic [7:0] O_INT_REQ, O_LAMP_INT;
  int num_errors = 0;
  int check_count = 0;
  int w;

  panel_ctrl #(.DEBOUNCE_CYCLES(4)) dut (.I_CLOCK(clk), .I_RESET(rst), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(wb_we), .I_WB_ADR(wb_adr), .I_WB_SEL(4'hf), .I_WB_DAT(wb_wd),
    .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_IRQ(O_IRQ), .I_REQ_SW(req_sw),
    .I_RESET_SW(rst_sw), .I_BOOT_SW(boot_sw), .I_SERVICED(serviced), .I_CPU_HALTED(halted),
    .I_CPU_RUNNING(running), .I_MEM_ADDR(mem_adr), .I_MEM_RD(mem_rd), .I_MEM_WR(mem_wr),
    .O_INT_REQ(O_INT_REQ), .O_LAMP_INT(O_LAMP_INT), .O_LAMP_HALT(O_LAMP_HALT),
    .O_LAMP_RUN(O_LAMP_RUN), .O_SYS_RESET(O_SYS_RESET), .O_BOOT_MODE(O_BOOT_MODE),
    .O_SHADOW_RD(O_SHADOW_RD), .O_RAM_RD(O_RAM_RD), .O_RAM_WR(O_RAM_WR));

  cpu_model partner (.i_clock(clk), .i_reset(rst), .i_int_req(O_INT_REQ), .i_mask(cpu_mask),
    .i_serve_en(serve), .i_state(cpu_state), .o_serviced(serviced), .o_halted(halted),
    .o_running(running));

  // ---------------------------------------------------------------
  // helpers: every task is entered and left just after a rising edge
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask
  // classic cycle: hold everything until ack is seen at an edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wd <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (O_WB_ACK !== 1'b1 && n < 20);
    rd = O_WB_DAT;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (O_WB_ACK !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    @(posedge clk);
  endtask
  // outputs follow the access one cycle late
  task automatic mem(input logic [15:0] a, input logic r, input logic [2:0] exp);
    mem_adr <= a;
    mem_rd <= r;
    mem_wr <= !r;
    cycles(2);
    cmp("steer", {29'h0, exp}, {29'h0, O_SHADOW_RD, O_RAM_RD, O_RAM_WR});
    mem_rd <= 1'b0;
    mem_wr <= 1'b0;
    @(posedge clk);
  endtask
  // held well past the debounce window, then released just as long
  task automatic press(input int n);
    req_sw[n] <= 1'b1;
    cycles(12);
    req_sw[n] <= 1'b0;
    cycles(12);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, cyc, stb, wb_we, rst_sw, boot_sw, mem_rd, mem_wr, serve} = 9'h100;
    {wb_adr, req_sw, cpu_mask, wb_wd, mem_adr, cpu_state} = '0;
    cycles(5);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, REG_STATUS, 32'h0);
    cmp("reg reset", 32'h0, rd);
    wb(1'b0, REG_MASK, 32'h0);
    cmp("reg reset", 32'h0, rd);
    wb(1'b0, REG_PANEL, 32'h0);
    cmp("reg reset", 32'h0, rd);
    wb(1'b0, 8'h10, 32'h0);
    cmp("reg reset", 32'h0, rd);
    $display("test regs done");
    req_sw[3] <= 1'b1;
    cycles(2);
    req_sw[3] <= 1'b0;
    cycles(12);
    cmp("bounce", 32'h0, {24'h0, O_INT_REQ});
    wb(1'b1, REG_MASK, 32'h1ff);
    for (int n = 0; n < 8; n++) begin
      press(n);
      cmp("pending", (32'h2 << n) - 1, {24'h0, O_INT_REQ});
      cmp("lamp", (32'h2 << n) - 1, {24'h0, O_LAMP_INT});
    end
    cmp("irq", 32'h1, {31'h0, O_IRQ});
    wb(1'b0, REG_STATUS, 32'h0);
    cmp("events", 32'h0ff, rd);
    cycles(2);
    cmp("irq clear", 32'h0, {31'h0, O_IRQ});
    $display("test press done");
    cpu_mask <= 8'hfe;
    serve <= 1'b1;
    cycles(30);
    cmp("masked", 32'hfe, {24'h0, O_LAMP_INT});
    cpu_mask <= 8'h00;
    cycles(30);
    cmp("served", 32'h0, {24'h0, O_LAMP_INT});
    serve <= 1'b0;
    $display("test service done");
    wb(1'b1, REG_SOFT_REQ, 32'h0a5);
    cycles(3);
    cmp("soft", 32'ha5, {24'h0, O_INT_REQ});
    rst_sw <= 1'b1;
    w = 0;
    while (O_SYS_RESET !== 1'b1 && w < 40) begin
      @(posedge clk);
      w++;
    end
    cmp("cleared", 32'h0, {24'h0, O_INT_REQ});
    w = 0;
    wr_seen = 1'b0;
    while (O_SYS_RESET === 1'b1 && w < 100) begin
      w++;
      wr_seen = wr_seen | (O_RAM_WR !== 1'b0);
      @(posedge clk);
    end
    cmp("pulse", 32'd20, w);
    cmp("no ram write", 32'h0, {31'h0, wr_seen});
    rst_sw <= 1'b0;
    cycles(12);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      cpu_state <= i[1:0];
      cycles(1100);
      cmp("lamps", i, {30'h0, O_LAMP_HALT, O_LAMP_RUN});
    end
    $display("test lamps done");
    boot_sw <= 1'b1;
    cycles(12);
    cmp("boot", 32'h1, {31'h0, O_BOOT_MODE});
    mem(SHADOW_TOP, 1'b1, 3'b100);
    mem(16'h0100, 1'b1, 3'b010);
    mem(16'h0010, 1'b0, 3'b001);
    boot_sw <= 1'b0;
    cycles(12);
    cmp("boot off", 32'h0, {31'h0, O_BOOT_MODE});
    mem(16'h0000, 1'b1, 3'b010);
    $display("test boot done");
    wrap_up();
  end
endmodule
